// ==== sdc_defs.svh ====
// sdc_defs.svh: timing counts and ratio figures for the stereo dac clock and power control
`ifndef SDC_DEFS_SVH
`define SDC_DEFS_SVH
// system clock rate in mhz (40 ns period)
`define SDC_CLK_MHZ 25
// fast power-up time in microseconds
`define SDC_FAST_PWRUP_US 50
// fast power-up time in clock cycles
`define SDC_FAST_PWRUP_CYC (`SDC_FAST_PWRUP_US * `SDC_CLK_MHZ)
// soft power-up clamp time in frame periods
`define SDC_CLAMP_FRAMES 1000
// soft power-up ramp time in frame periods
`define SDC_RAMP_FRAMES 10000
// bit clock edges in one frame phase that prove an external bit clock
`define SDC_EXT_EDGES 16
// silent frame periods that drop back to the internal bit clock
`define SDC_MISS_FRAMES 2
// internal master clock counts per frame for each valid ratio
`define SDC_R128 11'h080
`define SDC_R192 11'h0C0
`define SDC_R256 11'h100
`define SDC_R384 11'h180
`define SDC_R512 11'h200
// saturation limit of the master clock counter
`define SDC_MCNT_MAX 11'h7FF
`endif

// ==== sdc_pkg.sv ====
// sdc_pkg.sv: types shared by the stereo dac clock and power control
`default_nettype none
package sdc_pkg;
    // master to frame ratio after optional halving
    typedef enum logic [2:0] {
        SDC_R_BAD = 3'b000,
        SDC_R_128 = 3'b001,
        SDC_R_192 = 3'b010,
        SDC_R_256 = 3'b011,
        SDC_R_384 = 3'b100,
        SDC_R_512 = 3'b101
    } sdc_ratio_type;
    // power sequencing states
    typedef enum logic [2:0] {
        SDC_P_OFF = 3'b000,
        SDC_P_FAST = 3'b001,
        SDC_P_CLAMP = 3'b010,
        SDC_P_RAMP = 3'b011,
        SDC_P_RUN = 3'b100
    } sdc_pwr_type;
endpackage : sdc_pkg
`default_nettype wire

// ==== sdc_ctrl.sv ====
// sdc_ctrl.sv: speed detection, bit clock selection, format, de-emphasis, power and mute control
// Overview of operation
// - speed mode follows master to frame ratio
// - single speed ratios 256 to 1024
// - double speed ratios 128 to 384
// - two silent frames select internal bit clock
// - internal bit clock 32, 48, 64 per frame
// - internal bit clock behaves like external
// - sixteen edges per phase select external
// - external falls back after two silent frames
// - three format bits pick data format
// - de-emphasis only in single speed
// - reset holds defaults, quiescent low, low power
// - fast power-up takes about 50 us
// - soft power-up clamps, ramps, then plays
// - power-down stops audio, connects current sink
// - mute high in init, reset, mute, bad ratio
// - control port asynchronous, pins static when idle
// - halve bit divides master clock by two
// - select pin falling edge selects spi mode
`timescale 1ns/100ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_ctrl
    import sdc_pkg::*;
#(
    parameter int CLAMP_FRAMES = `SDC_CLAMP_FRAMES,
    parameter int RAMP_FRAMES = `SDC_RAMP_FRAMES,
    parameter int FAST_CYC = `SDC_FAST_PWRUP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic master_clock,
    input wire logic frame_clock,
    input wire logic bit_clock_in,
    input wire logic serial_audio_data,
    input wire logic master_clock_halve,
    input wire logic format_sel_0,
    input wire logic format_sel_1,
    input wire logic format_sel_2,
    input wire logic [1:0] deemph_sel,
    input wire logic power_down_bit,
    input wire logic soft_powerup,
    input wire logic mute_req,
    input wire logic addr_or_select_pin,
    output logic speed_double,
    output logic ratio_valid,
    output logic ext_bit_clock_mode,
    output logic bit_clock_out,
    output logic [6:0] bits_per_frame,
    output logic [2:0] format_out,
    output logic data_out,
    output logic [1:0] deemph_filter,
    output logic quiescent_reference,
    output logic output_clamp,
    output logic output_ramp,
    output logic audio_run,
    output logic current_sink,
    output logic mute_control_out,
    output logic spi_mode
);
    // half period of the internal bit clock in internal master clock counts
    function automatic logic [3:0] half_per(input sdc_ratio_type r, input logic [6:0] bpf);
        logic [3:0] h;
        h = 4'h1;
        unique case (r)
            SDC_R_128: h = (bpf == 7'h20) ? 4'h2 : 4'h1;
            SDC_R_192: h = 4'h2;
            SDC_R_256: h = (bpf == 7'h20) ? 4'h4 : 4'h2;
            SDC_R_384: h = 4'h4;
            SDC_R_512: h = (bpf == 7'h20) ? 4'h8 : 4'h4;
            SDC_R_BAD: h = 4'h1;
        endcase
        return h;
    endfunction : half_per
    // input history for edge detection
    logic mclk_d_ff, fclk_d_ff, bclk_d_ff, sel_d_ff;
    logic mclk_rise, fclk_rise, fclk_edge, bclk_rise;
    assign mclk_rise = master_clock & ~mclk_d_ff;
    assign fclk_rise = frame_clock & ~fclk_d_ff;
    assign fclk_edge = frame_clock ^ fclk_d_ff;
    assign bclk_rise = bit_clock_in & ~bclk_d_ff;
    // ratio measurement state
    logic halve_ph_ff, nxt_halve_ph;       // divide-by-two phase
    logic [10:0] mcnt_ff, nxt_mcnt;        // internal master edges this frame
    sdc_ratio_type ratio_ff, nxt_ratio;    // last measured ratio
    logic mtick;                           // one internal master clock edge
    // master clock halving and ratio classification
    always_comb begin
        nxt_halve_ph = halve_ph_ff;
        mtick = 1'b0;
        if (mclk_rise) begin
            if (master_clock_halve) begin
                nxt_halve_ph = ~halve_ph_ff;
                mtick = halve_ph_ff;
            end else begin
                mtick = 1'b1;
            end
        end
        nxt_mcnt = mcnt_ff;
        nxt_ratio = ratio_ff;
        if (fclk_rise) begin
            // classify the count gathered over the finished frame
            unique case (mcnt_ff)
                `SDC_R128: nxt_ratio = SDC_R_128;
                `SDC_R192: nxt_ratio = SDC_R_192;
                `SDC_R256: nxt_ratio = SDC_R_256;
                `SDC_R384: nxt_ratio = SDC_R_384;
                `SDC_R512: nxt_ratio = SDC_R_512;
                default: nxt_ratio = SDC_R_BAD;
            endcase
            nxt_mcnt = {10'h000, mtick};
        end else if (mtick && mcnt_ff != `SDC_MCNT_MAX) begin
            nxt_mcnt = mcnt_ff + 11'h001;
        end
    end
    // registers for edge history and ratio measurement
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mclk_d_ff <= 1'b0;
            fclk_d_ff <= 1'b0;
            bclk_d_ff <= 1'b0;
            halve_ph_ff <= 1'b0;
            mcnt_ff <= 11'h000;
            ratio_ff <= SDC_R_BAD;
        end else begin
            mclk_d_ff <= master_clock;
            fclk_d_ff <= frame_clock;
            bclk_d_ff <= bit_clock_in;
            halve_ph_ff <= nxt_halve_ph;
            mcnt_ff <= nxt_mcnt;
            ratio_ff <= nxt_ratio;
        end
    end
    // bit clock mode detection state
    logic [4:0] ecnt_ff, nxt_ecnt;   // bit clock edges in this phase
    logic seen_ff, nxt_seen;         // any bit clock edge this frame period
    logic [1:0] miss_ff, nxt_miss;   // consecutive silent frame periods
    logic ext_ff, nxt_ext;           // external bit clock mode
    // count edges per phase and silent frame periods
    always_comb begin
        nxt_ecnt = ecnt_ff;
        nxt_seen = seen_ff | bclk_rise;
        nxt_miss = miss_ff;
        nxt_ext = ext_ff;
        if (fclk_edge) begin
            nxt_ecnt = {4'h0, bclk_rise};  // restart each phase
        end else if (bclk_rise && ecnt_ff != 5'h1F) begin
            nxt_ecnt = ecnt_ff + 5'h01;
        end
        if (nxt_ecnt == 5'(`SDC_EXT_EDGES)) begin
            nxt_ext = 1'b1;
        end
        if (fclk_rise) begin
            nxt_seen = bclk_rise;
            if (seen_ff) begin
                nxt_miss = 2'h0;
            end else if (miss_ff != 2'(`SDC_MISS_FRAMES)) begin
                nxt_miss = miss_ff + 2'h1;
            end
            if (!seen_ff && miss_ff == 2'(`SDC_MISS_FRAMES - 1)) begin
                nxt_ext = 1'b0;
            end
        end
    end
    // registers for bit clock mode detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ecnt_ff <= 5'h00;
            seen_ff <= 1'b0;
            miss_ff <= 2'h0;
            ext_ff <= 1'b0;
        end else begin
            ecnt_ff <= nxt_ecnt;
            seen_ff <= nxt_seen;
            miss_ff <= nxt_miss;
            ext_ff <= nxt_ext;
        end
    end
    // internal bit clock generation state
    logic [2:0] fmt;                 // selected interface format
    logic [6:0] bpf;                 // bit clocks per frame
    logic [3:0] div_ff, nxt_div;     // master counts in this half period
    logic ibclk_ff, nxt_ibclk;       // internal bit clock level
    assign fmt = {format_sel_2, format_sel_1, format_sel_0};
    // derive the internal bit clock, realigned on each frame edge
    always_comb begin
        bpf = (ratio_ff == SDC_R_192 || ratio_ff == SDC_R_384) ? 7'h30 : (fmt == 3'h1) ? 7'h20 : 7'h40;
        nxt_div = div_ff;
        nxt_ibclk = ibclk_ff;
        if (fclk_edge) begin
            nxt_div = 4'h0;                 // lock to the frame clock
            nxt_ibclk = 1'b0;
        end else if (mtick) begin
            if (div_ff + 4'h1 >= half_per(ratio_ff, bpf)) begin
                nxt_div = 4'h0;
                nxt_ibclk = ~ibclk_ff;
            end else begin
                nxt_div = div_ff + 4'h1;
            end
        end
    end
    // registers for the internal bit clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_ff <= 4'h0;
            ibclk_ff <= 1'b0;
        end else begin
            div_ff <= nxt_div;
            ibclk_ff <= nxt_ibclk;
        end
    end
    // power sequencing state
    sdc_pwr_type pwr_ff, nxt_pwr;
    logic [13:0] pcnt_ff, nxt_pcnt;  // cycles or frames spent in this state
    // power-up and power-down sequence
    always_comb begin
        nxt_pwr = pwr_ff;
        nxt_pcnt = pcnt_ff;
        unique case (pwr_ff)
            SDC_P_OFF: begin
                nxt_pcnt = 14'h0000;
                if (!power_down_bit) begin
                    nxt_pwr = soft_powerup ? SDC_P_CLAMP : SDC_P_FAST;
                end
            end
            SDC_P_FAST: begin
                nxt_pcnt = pcnt_ff + 14'h0001;
                if (pcnt_ff == 14'(FAST_CYC - 1)) begin
                    nxt_pwr = SDC_P_RUN;
                end
            end
            SDC_P_CLAMP: begin
                if (fclk_rise) begin
                    nxt_pcnt = pcnt_ff + 14'h0001;
                    if (pcnt_ff == 14'(CLAMP_FRAMES - 1)) begin
                        nxt_pwr = SDC_P_RAMP;
                        nxt_pcnt = 14'h0000;
                    end
                end
            end
            SDC_P_RAMP: begin
                if (fclk_rise) begin
                    nxt_pcnt = pcnt_ff + 14'h0001;
                    if (pcnt_ff == 14'(RAMP_FRAMES - 1)) begin
                        nxt_pwr = SDC_P_RUN;
                    end
                end
            end
            SDC_P_RUN: nxt_pcnt = 14'h0000;
            default: nxt_pwr = SDC_P_OFF;
        endcase
        if (power_down_bit) begin
            nxt_pwr = SDC_P_OFF;
            nxt_pcnt = 14'h0000;
        end
    end
    // registers for power sequencing; reset holds the off state
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pwr_ff <= SDC_P_OFF;
            pcnt_ff <= 14'h0000;
        end else begin
            pwr_ff <= nxt_pwr;
            pcnt_ff <= nxt_pcnt;
        end
    end
    // control port mode state
    logic sel_ok_ff, nxt_sel_ok;     // pin history valid after reset
    logic spi_ff, nxt_spi;           // spi mode latched
    // spi selection on a falling edge of the shared pin
    always_comb begin
        nxt_sel_ok = 1'b1;
        nxt_spi = spi_ff | (sel_ok_ff & sel_d_ff & ~addr_or_select_pin);
    end
    // registers for control port mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sel_ok_ff <= 1'b0;
            sel_d_ff <= 1'b0;
            spi_ff <= 1'b0;
        end else begin
            sel_ok_ff <= nxt_sel_ok;
            sel_d_ff <= addr_or_select_pin;
            spi_ff <= nxt_spi;
        end
    end
    // registered outputs
    logic dbl, vld;
    logic [1:0] nxt_dem;
    assign vld = (ratio_ff != SDC_R_BAD);
    assign dbl = (ratio_ff == SDC_R_128 || ratio_ff == SDC_R_192);
    assign nxt_dem = dbl ? 2'h0 : deemph_sel;
    // output registers; reset shows muted, powered down
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            speed_double <= 1'b0;
            ratio_valid <= 1'b0;
            ext_bit_clock_mode <= 1'b0;
            bit_clock_out <= 1'b0;
            bits_per_frame <= 7'h40;
            format_out <= 3'h0;
            data_out <= 1'b0;
            deemph_filter <= 2'h0;
            quiescent_reference <= 1'b0;
            output_clamp <= 1'b0;
            output_ramp <= 1'b0;
            audio_run <= 1'b0;
            current_sink <= 1'b1;
            mute_control_out <= 1'b1;
            spi_mode <= 1'b0;
        end else begin
            speed_double <= dbl;
            ratio_valid <= vld;
            ext_bit_clock_mode <= ext_ff;
            bit_clock_out <= ext_ff ? bit_clock_in : ibclk_ff;
            bits_per_frame <= bpf;
            format_out <= fmt;
            data_out <= serial_audio_data;
            deemph_filter <= nxt_dem;
            quiescent_reference <= (pwr_ff != SDC_P_OFF);
            output_clamp <= (pwr_ff == SDC_P_CLAMP);
            output_ramp <= (pwr_ff == SDC_P_RAMP);
            audio_run <= (pwr_ff == SDC_P_RUN);
            current_sink <= (pwr_ff == SDC_P_OFF);
            mute_control_out <= (pwr_ff != SDC_P_RUN) | mute_req | ~vld;
            spi_mode <= spi_ff;
        end
    end
endmodule : sdc_ctrl
`default_nettype wire

// ==== sdc_ctrl_props.sv ====
// sdc_ctrl_props.sv: concurrent checks on the sdc_ctrl ports
`timescale 1ns/100ps
`default_nettype none
`include "sdc_defs.svh"
module sdc_ctrl_props #(
    parameter int FAST_CYC = `SDC_FAST_PWRUP_CYC
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic bit_clock_in,
    input wire logic power_down_bit,
    input wire logic mute_req,
    input wire logic addr_or_select_pin,
    input wire logic speed_double,
    input wire logic ratio_valid,
    input wire logic ext_bit_clock_mode,
    input wire logic bit_clock_out,
    input wire logic [6:0] bits_per_frame,
    input wire logic [1:0] deemph_filter,
    input wire logic quiescent_reference,
    input wire logic output_clamp,
    input wire logic output_ramp,
    input wire logic audio_run,
    input wire logic current_sink,
    input wire logic mute_control_out,
    input wire logic spi_mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // cycles spent powered but not yet playing
    logic [15:0] fast_cnt_ff;
    logic [15:0] nxt_fast_cnt;
    // count while the reference is up and audio has not started
    always_comb begin
        nxt_fast_cnt = (quiescent_reference && !audio_run) ? fast_cnt_ff + 16'h0001 : 16'h0000;
    end
    // register the count, cleared in reset
    always_ff @(posedge clk) begin
        fast_cnt_ff <= rst_n ? nxt_fast_cnt : 16'h0000;
    end
    a_reset_defaults: assert property (disable iff (1'b0) !rst_n |=> mute_control_out && current_sink && !quiescent_reference)
        else $error("outputs not at defaults after reset");
    a_mute_needs_run: assert property (!mute_control_out |-> audio_run && ratio_valid && !$past(mute_req))
        else $error("mute low outside playback");
    a_pdn_forces_off: assert property (power_down_bit |=> ##1 (current_sink && !audio_run && !quiescent_reference))
        else $error("power-down did not stop audio");
    a_deemph_single_only: assert property (speed_double |-> deemph_filter == 2'h0)
        else $error("de-emphasis in double speed");
    a_double_is_valid: assert property (speed_double |-> ratio_valid)
        else $error("double speed on a bad ratio");
    a_bpf_legal: assert property (bits_per_frame inside {7'h20, 7'h30, 7'h40})
        else $error("bits per frame not 32, 48 or 64");
    a_fast_length: assert property ($rose(audio_run) && !$past(output_ramp) |-> fast_cnt_ff == 16'(FAST_CYC))
        else $error("fast power-up length wrong");
    a_clamp_then_ramp: assert property ($fell(output_clamp) |-> output_ramp || current_sink)
        else $error("clamp not followed by ramp");
    a_ramp_then_run: assert property ($fell(output_ramp) |-> audio_run || current_sink)
        else $error("ramp not followed by playback");
    a_ext_bck_follows: assert property (ext_bit_clock_mode |-> bit_clock_out == $past(bit_clock_in))
        else $error("bit clock out not the external one");
    a_spi_on_fall: assert property ($past(rst_n) && $fell(addr_or_select_pin) |-> ##2 spi_mode)
        else $error("select fall did not pick spi");
    a_spi_sticky: assert property (spi_mode |=> spi_mode)
        else $error("spi mode dropped");
    c_run: cover property ($rose(audio_run));
    c_ext: cover property ($rose(ext_bit_clock_mode));
    c_dbl: cover property ($rose(speed_double));
    c_spi: cover property ($rose(spi_mode));
endmodule : sdc_ctrl_props
`default_nettype wire

// ==== sdc_src_model.sv ====
// sdc_src_model.sv: audio source model making master, frame and bit clocks
`timescale 1ns/100ps
`default_nettype none
module sdc_src_model (
    input wire logic clk,
    input wire logic [10:0] ratio_raw,
    input wire logic bck_on,
    output logic master_clock,
    output logic frame_clock,
    output logic bit_clock_in
);
    // phase counter, two clk cycles per master period
    logic [11:0] cnt = 12'h000;
    // frame spans ratio_raw master periods, locked to the master clock
    always @(posedge clk) begin
        #1;
        cnt = (cnt >= {ratio_raw, 1'b0} - 12'h001) ? 12'h000 : cnt + 12'h001;
    end
    assign master_clock = cnt[0];
    assign frame_clock = ({1'b0, cnt[11:1]} < {1'b0, ratio_raw[10:1], 1'b0} >> 1) ? 1'b1 : 1'b0;
    // bit clock stands still low when switched off
    assign bit_clock_in = bck_on & cnt[2];
endmodule : sdc_src_model
`default_nettype wire

// ==== tb_top.sv ====
// tb_top.sv: directed bench for sdc_ctrl with an audio source model
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import sdc_pkg::*;
    localparam int FAST_CYC = 8;
    // numbers of the outputs that wait_lvl can watch
    localparam int W_EXT = 0, W_BCK = 1, W_RUN = 2, W_CLAMP = 3, W_RAMP = 4;
    logic clk, rst_n, master_clock, frame_clock, bit_clock_in, serial_audio_data, master_clock_halve;
    logic format_sel_0, format_sel_1, format_sel_2, power_down_bit, soft_powerup, mute_req, addr_or_select_pin;
    logic [1:0] deemph_sel, deemph_filter;
    logic speed_double, ratio_valid, ext_bit_clock_mode, bit_clock_out, data_out, quiescent_reference;
    logic output_clamp, output_ramp, audio_run, current_sink, mute_control_out, spi_mode, bck_on;
    logic [6:0] bits_per_frame;
    logic [2:0] format_out;
    logic [10:0] ratio_raw;
    int error_cnt = 0, num_checks = 0, n;
    int raw_t[6] = '{128, 192, 384, 768, 1024, 300};
    logic [5:0] halve_t = 6'b011000, valid_t = 6'b011111, dbl_t = 6'b000011;
    logic [6:0] bpf_t[6] = '{7'h40, 7'h30, 7'h30, 7'h30, 7'h40, 7'h40};
    assign serial_audio_data = bit_clock_in ^ frame_clock;
    // data in as the design sampled it at the last edge
    logic sd_prev;
    always @(posedge clk) sd_prev <= serial_audio_data;
    sdc_src_model sdc_src_model_i (.clk(clk), .ratio_raw(ratio_raw), .bck_on(bck_on), .master_clock(master_clock),
        .frame_clock(frame_clock), .bit_clock_in(bit_clock_in));
    sdc_ctrl #(.CLAMP_FRAMES(3), .RAMP_FRAMES(5), .FAST_CYC(FAST_CYC)) sdc_ctrl_i (.clk(clk), .rst_n(rst_n),
        .master_clock(master_clock), .frame_clock(frame_clock), .bit_clock_in(bit_clock_in),
        .serial_audio_data(serial_audio_data), .master_clock_halve(master_clock_halve), .format_sel_0(format_sel_0),
        .format_sel_1(format_sel_1), .format_sel_2(format_sel_2), .deemph_sel(deemph_sel),
        .power_down_bit(power_down_bit), .soft_powerup(soft_powerup), .mute_req(mute_req),
        .addr_or_select_pin(addr_or_select_pin), .speed_double(speed_double), .ratio_valid(ratio_valid),
        .ext_bit_clock_mode(ext_bit_clock_mode), .bit_clock_out(bit_clock_out), .bits_per_frame(bits_per_frame),
        .format_out(format_out), .data_out(data_out), .deemph_filter(deemph_filter),
        .quiescent_reference(quiescent_reference), .output_clamp(output_clamp), .output_ramp(output_ramp),
        .audio_run(audio_run), .current_sink(current_sink), .mute_control_out(mute_control_out), .spi_mode(spi_mode));
    // compare one value and count it
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    // let n edges pass, then step off the edge
    task automatic tick(input int cyc);
        repeat (cyc) @(posedge clk);
        #1;
    endtask : tick
    // level of one watched output, picked by number
    function automatic logic pick(input int sel);
        case (sel)
            W_EXT: return ext_bit_clock_mode;
            W_BCK: return bit_clock_out;
            W_RUN: return audio_run;
            W_CLAMP: return output_clamp;
            W_RAMP: return output_ramp;
            default: return 1'b0;
        endcase
    endfunction : pick
    // bounded wait for a level; running out ends the run
    task automatic wait_lvl(input int sel, input logic want, input int lim, output int cnt);
        cnt = 0;
        while (pick(sel) !== want && cnt < lim) begin
            tick(1);
            cnt++;
        end
        if (cnt >= lim) begin
            error_cnt++;
            report_and_stop();
        end
    endtask : wait_lvl
    // print counts and verdict, then stop
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // settings stay static except when changed on purpose
    initial begin
        {rst_n, master_clock_halve, format_sel_0, format_sel_1, format_sel_2, soft_powerup, mute_req} = 7'h00;
        {power_down_bit, addr_or_select_pin, bck_on, deemph_sel, ratio_raw} = {3'h7, 2'h0, 11'h100};
        tick(3);
        check({mute_control_out, current_sink, quiescent_reference, bits_per_frame}, 16'h0340);
        rst_n = 1'b1;
        tick(1600);
        check({ratio_valid, speed_double, ext_bit_clock_mode, quiescent_reference}, 16'hA);
        deemph_sel = 2'h2;
        {format_sel_2, format_sel_1, format_sel_0} = 3'h5;
        tick(4);
        check({deemph_filter, 1'b0, format_out}, 16'h25);
        {bck_on, format_sel_2, format_sel_0} = 3'h0;
        wait_lvl(W_EXT, 1'b0, 1600, n);
        check(n > 500, 1);
        check(bits_per_frame, 16'h40);
        format_sel_0 = 1'b1;
        tick(4);
        check(bits_per_frame, 16'h20);
        wait_lvl(W_BCK, 1'b1, 64, n);
        {format_sel_0, bck_on} = 2'b01;
        wait_lvl(W_EXT, 1'b1, 1200, n);
        power_down_bit = 1'b0;
        wait_lvl(W_RUN, 1'b1, 64, n);
        check(16'(n), 16'(FAST_CYC + 2));
        check(mute_control_out, 0);
        check(data_out, sd_prev);
        mute_req = 1'b1;
        tick(2);
        check(mute_control_out, 1);
        mute_req = 1'b0;
        tick(2);
        check(mute_control_out, 0);
        for (int i = 0; i < 6; i++) begin
            ratio_raw = raw_t[i][10:0];
            master_clock_halve = halve_t[i];
            tick(6 * raw_t[i] + 8);
            check({ratio_valid, speed_double, mute_control_out}, {valid_t[i], dbl_t[i], ~valid_t[i]});
            check(deemph_filter, dbl_t[i] ? 16'h0 : 16'h2);
            if (valid_t[i]) begin
                check(bits_per_frame, bpf_t[i]);
            end
        end
        {ratio_raw, master_clock_halve, power_down_bit} = {11'h100, 2'b01};
        tick(1600);
        check({current_sink, audio_run, mute_control_out, quiescent_reference}, 16'hA);
        {soft_powerup, power_down_bit} = 2'b10;
        wait_lvl(W_CLAMP, 1'b1, 16, n);
        wait_lvl(W_RAMP, 1'b1, 2200, n);
        wait_lvl(W_RUN, 1'b1, 3200, n);
        check({output_clamp, output_ramp}, 0);
        addr_or_select_pin = 1'b0;
        tick(3);
        check(spi_mode, 1);
        {rst_n, power_down_bit} = 2'b01;
        tick(2);
        check({spi_mode, current_sink, mute_control_out, quiescent_reference}, 16'h6);
        rst_n = 1'b1;
        tick(2);
        report_and_stop();
    end
endmodule : tb_top
bind sdc_ctrl sdc_ctrl_props #(.FAST_CYC(FAST_CYC)) sdc_ctrl_props_i (.clk(clk), .rst_n(rst_n),
    .bit_clock_in(bit_clock_in), .power_down_bit(power_down_bit), .mute_req(mute_req),
    .addr_or_select_pin(addr_or_select_pin), .speed_double(speed_double), .ratio_valid(ratio_valid),
    .ext_bit_clock_mode(ext_bit_clock_mode), .bit_clock_out(bit_clock_out), .bits_per_frame(bits_per_frame),
    .deemph_filter(deemph_filter), .quiescent_reference(quiescent_reference), .output_clamp(output_clamp),
    .output_ramp(output_ramp), .audio_run(audio_run), .current_sink(current_sink),
    .mute_control_out(mute_control_out), .spi_mode(spi_mode));
`default_nettype wire
